// [rtl/scrb_pkg.sv]
// Constants for the serial configuration register bank.
package scrb_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int unsigned SHIFT_W  = 18;
  localparam int unsigned DATA_W   = 14;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned NUM_REGS = 16;
  localparam int unsigned DATA_LSB = 4;
  localparam int unsigned DATA_MSB = 17;
  localparam int unsigned ADDR_MSB = 3;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [3:0] ADDR_PLL_MODE   = 4'h0;
  localparam logic [3:0] ADDR_LOCK_OUT   = 4'h1;
  localparam logic [3:0] ADDR_DIV_INT    = 4'h3;
  localparam logic [3:0] ADDR_DIV_FRAC_H = 4'h4;
  localparam logic [3:0] ADDR_REF_LOCK   = 4'h5;
  localparam logic [3:0] ADDR_CAL_DET    = 4'h6;
  localparam logic [3:0] ADDR_FILT_FINE  = 4'h7;
  localparam logic [3:0] ADDR_GAIN_IND   = 4'h8;
  localparam logic [3:0] ADDR_TX_SRC     = 4'h9;
  localparam logic [3:0] ADDR_RX_GAIN    = 4'hB;
  localparam logic [3:0] ADDR_TX_GAIN    = 4'hC;
  localparam logic [3:0] ADDR_REFCLK     = 4'hE;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned BIT_FRAC_MODE   = 10;
  localparam int unsigned BIT_LOCK_CMOS   = 12;
  localparam int unsigned BIT_LOCK_PULLUP = 9;
  localparam int unsigned BIT_LOCK_EN     = 5;
  localparam int unsigned BIT_REF_DIV2    = 2;
  localparam int unsigned INT_MSB         = 7;
  localparam int unsigned FRAC_LO_LSB     = 8;
  localparam int unsigned FRAC_LO_MSB     = 13;
  localparam int unsigned BIT_REFCLK_DIV2 = 10;
  localparam int unsigned BIT_REFCLK_EN   = 9;
  localparam int unsigned DET_GAIN_LSB    = 11;
  localparam int unsigned DET_GAIN_MSB    = 12;
  localparam int unsigned BIT_TX_CAL      = 1;
  localparam int unsigned BIT_RX_CAL      = 0;
  localparam int unsigned HP_LSB          = 12;
  localparam int unsigned HP_MSB          = 13;
  localparam int unsigned TX_FINE_LSB     = 3;
  localparam int unsigned TX_FINE_MSB     = 5;
  localparam int unsigned RX_FINE_MSB     = 2;
  localparam int unsigned COARSE_MSB      = 1;
  localparam int unsigned BIT_RX_SERIAL   = 12;
  localparam int unsigned BIT_IND_ALWAYS  = 10;
  localparam int unsigned IND_SEL_LSB     = 8;
  localparam int unsigned IND_SEL_MSB     = 9;
  localparam int unsigned BIT_TX_SERIAL   = 10;
  localparam int unsigned RX_GAIN_MSB     = 6;
  localparam int unsigned TX_GAIN_MSB     = 5;

  // ==========================================================================
  // Reset contents (recommended settings)
  // ==========================================================================
  localparam logic [13:0] RESET_VAL [16] = '{
    14'h1740, 14'h119A, 14'h1003, 14'h0079, 14'h3666, 14'h00A4, 14'h0060, 14'h1022,
    14'h2021, 14'h03B5, 14'h1DA4, 14'h007F, 14'h0140, 14'h0E92, 14'h033B, 14'h0145
  };

endpackage

// [rtl/scrb_top.sv]
// Serial configuration register bank with 3-wire write port and decoded fields.
`timescale 1ns/1ps
// Operation
// - Sixteen 14-bit registers, written by 18-bit words: data high, address low.
// - Words arrive most significant bit first, framed by active-low chip select.
// - While select is low, each serial clock rising edge shifts one bit in.
// - Select rising copies shift register data into the addressed register.
// - Only the last 18 bits are kept; frames of any length are accepted.
// - Register 0 bit 10 selects fractional-N (1) or integer-N (0) synthesizer.
// - Register 1 bit 12 selects push-pull (1) or open-drain (0) lock output.
// - Register 5 bit 9 enables lock pullup, only in open-drain mode.
// - Register 5 bit 5 enables lock output; disabled means high impedance.
// - Enabled lock output is low when unlocked; when locked, push-pull drives high and open-drain releases to the pullup.
// - Register 5 bit 2 sets synthesizer reference divider: 0 one, 1 two.
// - Integer divider in reg 3 low byte; 20-bit fraction from regs 4 and 3.
// - Register 14 bit 10 sets refclk output divider, bit 9 enables it.
// - Register 6 bits 12:11 set calibration detector gain 9 to 39 dB.
// - Register 6 bits 1 and 0 select transmit or receive calibration.
// - Register 7 bits 13:12 select receive highpass corner when pin low.
// - Register 7 holds transmit fine trim 5:3 and receive fine trim 2:0.
// - Register 8 bits 1:0 hold the shared lowpass coarse corner.
// - Register 8 bit 12 takes receive gain from register or parallel pins.
// - Register 8 bit 10 forces indicator on; else highpass pin enables it.
// - Register 8 bits 9:8 route signal strength, temperature or power detector.
// - Writes are accepted and kept in every power mode.

// ============================================================================
// Top module
// ============================================================================
module scrb_top (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_CS_B,
  input  wire logic        I_SCLK,
  input  wire logic        I_SDATA,
  input  wire logic        I_PLL_LOCKED,
  input  wire logic        I_RX_TX_SELECT_PIN,
  input  wire logic        I_HIGHPASS_SELECT_PIN,
  input  wire logic [6:0]  I_PARALLEL_RX_GAIN_PINS,
  input  wire logic [5:0]  I_PARALLEL_TX_GAIN_PINS,
  output logic             O_REG_WRITE,
  output logic             O_FRAC_MODE,
  output logic             O_REF_DIV2,
  output logic [7:0]       O_INT_DIV,
  output logic [19:0]      O_FRAC_DIV,
  output logic             O_REFCLK_DIV2,
  output logic             O_REFCLK_EN,
  output logic [1:0]       O_DET_GAIN,
  output logic             O_TX_CAL,
  output logic             O_RX_CAL,
  output logic [1:0]       O_RX_HP_CORNER,
  output logic [2:0]       O_TX_LPF_FINE,
  output logic [2:0]       O_RX_LPF_FINE,
  output logic [1:0]       O_LPF_COARSE,
  output logic [6:0]       O_RX_GAIN,
  output logic [5:0]       O_TX_GAIN,
  output logic             O_IND_EN,
  output logic [1:0]       O_IND_SEL,
  output logic             O_LOCK_DET_OUT,
  output logic             O_LOCK_DET_OE,
  output logic             O_LOCK_PULLUP_EN
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int unsigned NSYNC = 19;

  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic             sclk_prev;
  logic             cs_b_prev;

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      sync1 <= '1;
      sync2 <= '1;
    end
    else
    begin
      sync1 <= {I_CS_B, I_SCLK, I_SDATA, I_PLL_LOCKED, I_RX_TX_SELECT_PIN,
                I_HIGHPASS_SELECT_PIN, I_PARALLEL_RX_GAIN_PINS, I_PARALLEL_TX_GAIN_PINS};
      sync2 <= sync1;
    end
  end

  logic       cs_b_s;
  logic       sclk_s;
  logic       sdata_s;
  logic       locked_s;
  logic       rx_tx_s;
  logic       hp_pin_s;
  logic [6:0] prx_gain_s;
  logic [5:0] ptx_gain_s;

  assign {cs_b_s, sclk_s, sdata_s, locked_s, rx_tx_s, hp_pin_s, prx_gain_s, ptx_gain_s} = sync2;

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      sclk_prev <= 1'b1;
      cs_b_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= sclk_s;
      cs_b_prev <= cs_b_s;
    end
  end

  // The serial clock is oversampled, so it must stay well below half
  // of the system clock rate for each edge to be seen once.
  logic shift_en;
  logic latch_en;

  assign shift_en = !cs_b_s && sclk_s && !sclk_prev;
  assign latch_en = cs_b_s && !cs_b_prev;

  // ==========================================================================
  // Shift register
  // ==========================================================================
  logic [scrb_pkg::SHIFT_W-1:0] shift_reg;

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      shift_reg <= '0;
    else if (shift_en)
      shift_reg <= {shift_reg[scrb_pkg::SHIFT_W-2:0], sdata_s};
  end

  // ==========================================================================
  // Register array
  // ==========================================================================
  logic [scrb_pkg::DATA_W-1:0] regs [scrb_pkg::NUM_REGS];
  logic [scrb_pkg::ADDR_W-1:0] wr_addr;
  logic [scrb_pkg::DATA_W-1:0] wr_data;

  assign wr_addr = shift_reg[scrb_pkg::ADDR_MSB:0];
  assign wr_data = shift_reg[scrb_pkg::DATA_MSB:scrb_pkg::DATA_LSB];

  // One-hot view of the register being loaded, used by the field checks.
  logic [scrb_pkg::NUM_REGS-1:0] wr_hit;

  always_comb
  begin
    wr_hit = '0;
    if (latch_en)
      wr_hit[wr_addr] = 1'b1;
  end

  // No pin gates the write, so the bank keeps loading in shutdown.
  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      for (int i = 0; i < scrb_pkg::NUM_REGS; i++)
        regs[i] <= scrb_pkg::RESET_VAL[i];
    end
    else if (latch_en)
      regs[wr_addr] <= wr_data;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_REG_WRITE <= 1'b0;
    else
      O_REG_WRITE <= latch_en;
  end

  // ==========================================================================
  // Decoded fields
  // ==========================================================================
  logic [13:0] r_mode;
  logic [13:0] r_lock;
  logic [13:0] r_int;
  logic [13:0] r_frac;
  logic [13:0] r_ref;
  logic [13:0] r_cal;
  logic [13:0] r_filt;
  logic [13:0] r_gind;
  logic [13:0] r_txsrc;
  logic [13:0] r_rxg;
  logic [13:0] r_txg;
  logic [13:0] r_rclk;

  assign r_mode  = regs[scrb_pkg::ADDR_PLL_MODE];
  assign r_lock  = regs[scrb_pkg::ADDR_LOCK_OUT];
  assign r_int   = regs[scrb_pkg::ADDR_DIV_INT];
  assign r_frac  = regs[scrb_pkg::ADDR_DIV_FRAC_H];
  assign r_ref   = regs[scrb_pkg::ADDR_REF_LOCK];
  assign r_cal   = regs[scrb_pkg::ADDR_CAL_DET];
  assign r_filt  = regs[scrb_pkg::ADDR_FILT_FINE];
  assign r_gind  = regs[scrb_pkg::ADDR_GAIN_IND];
  assign r_txsrc = regs[scrb_pkg::ADDR_TX_SRC];
  assign r_rxg   = regs[scrb_pkg::ADDR_RX_GAIN];
  assign r_txg   = regs[scrb_pkg::ADDR_TX_GAIN];
  assign r_rclk  = regs[scrb_pkg::ADDR_REFCLK];

  assign O_FRAC_MODE    = r_mode[scrb_pkg::BIT_FRAC_MODE];
  assign O_REF_DIV2     = r_ref[scrb_pkg::BIT_REF_DIV2];
  assign O_INT_DIV      = r_int[scrb_pkg::INT_MSB:0];
  assign O_FRAC_DIV     = {r_frac, r_int[scrb_pkg::FRAC_LO_MSB:scrb_pkg::FRAC_LO_LSB]};
  assign O_REFCLK_DIV2  = r_rclk[scrb_pkg::BIT_REFCLK_DIV2];
  assign O_REFCLK_EN    = r_rclk[scrb_pkg::BIT_REFCLK_EN];
  assign O_DET_GAIN     = r_cal[scrb_pkg::DET_GAIN_MSB:scrb_pkg::DET_GAIN_LSB];
  assign O_TX_CAL       = rx_tx_s && r_cal[scrb_pkg::BIT_TX_CAL];
  assign O_RX_CAL       = !rx_tx_s && r_cal[scrb_pkg::BIT_RX_CAL];
  assign O_RX_HP_CORNER = r_filt[scrb_pkg::HP_MSB:scrb_pkg::HP_LSB];
  assign O_TX_LPF_FINE  = r_filt[scrb_pkg::TX_FINE_MSB:scrb_pkg::TX_FINE_LSB];
  assign O_RX_LPF_FINE  = r_filt[scrb_pkg::RX_FINE_MSB:0];
  assign O_LPF_COARSE   = r_gind[scrb_pkg::COARSE_MSB:0];
  assign O_RX_GAIN      = r_gind[scrb_pkg::BIT_RX_SERIAL] ? r_rxg[scrb_pkg::RX_GAIN_MSB:0]
                                                          : prx_gain_s;
  assign O_TX_GAIN      = r_txsrc[scrb_pkg::BIT_TX_SERIAL] ? r_txg[scrb_pkg::TX_GAIN_MSB:0]
                                                           : ptx_gain_s;
  assign O_IND_EN       = r_gind[scrb_pkg::BIT_IND_ALWAYS] || hp_pin_s;
  assign O_IND_SEL      = r_gind[scrb_pkg::IND_SEL_MSB:scrb_pkg::IND_SEL_LSB];

  // ==========================================================================
  // Lock-detect pin
  // ==========================================================================
  logic lock_en;
  logic lock_cmos;

  assign lock_en   = r_ref[scrb_pkg::BIT_LOCK_EN];
  assign lock_cmos = r_lock[scrb_pkg::BIT_LOCK_CMOS];

  // Open-drain mode only pulls low; the high level comes from the pullup.
  assign O_LOCK_DET_OUT   = lock_cmos && locked_s;
  assign O_LOCK_DET_OE    = lock_en && (lock_cmos || !locked_s);
  assign O_LOCK_PULLUP_EN = lock_en && !lock_cmos && r_ref[scrb_pkg::BIT_LOCK_PULLUP];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);

  a_shift_msb_first: assert property (shift_en |=>
    shift_reg == {$past(shift_reg[scrb_pkg::SHIFT_W-2:0]), $past(sdata_s)})
    else $error("Shift register did not take the new bit at the bottom.");

  a_shift_hold_idle: assert property (cs_b_s && $stable(cs_b_s) |=> $stable(shift_reg))
    else $error("Shift register moved while select was high.");

  a_latch_on_rise: assert property (latch_en |=>
    regs[$past(wr_addr)] == $past(wr_data) && O_REG_WRITE)
    else $error("Register not loaded on select rising.");

  a_no_stray_write: assert property (!latch_en |=> $stable(regs[0]) && !O_REG_WRITE)
    else $error("Register changed without a select rising edge.");

  a_lock_disabled: assert property (!lock_en |-> !O_LOCK_DET_OE && !O_LOCK_PULLUP_EN)
    else $error("Lock pin driven while disabled.");

  a_lock_cmos_drive: assert property (lock_en && lock_cmos |->
    O_LOCK_DET_OE && O_LOCK_DET_OUT == locked_s)
    else $error("Push-pull lock output wrong.");

  a_lock_open_drain: assert property (lock_en && !lock_cmos |->
    !O_LOCK_DET_OUT && O_LOCK_DET_OE == !locked_s)
    else $error("Open-drain lock output wrong.");

  a_pullup_gate: assert property (O_LOCK_PULLUP_EN |-> !lock_cmos)
    else $error("Pullup enabled in push-pull mode.");

  a_cal_modes: assert property (!(O_TX_CAL && O_RX_CAL) &&
    (O_TX_CAL == (rx_tx_s && r_cal[scrb_pkg::BIT_TX_CAL])))
    else $error("Calibration mode decode wrong.");

  a_ind_enable: assert property (!hp_pin_s && !r_gind[scrb_pkg::BIT_IND_ALWAYS] |-> !O_IND_EN)
    else $error("Indicator enabled without cause.");

  a_rx_gain_src: assert property (!r_gind[scrb_pkg::BIT_RX_SERIAL] |->
    O_RX_GAIN == prx_gain_s)
    else $error("Receive gain not taken from parallel pins.");

  a_frac_mode_load: assert property (wr_hit[scrb_pkg::ADDR_PLL_MODE] |=>
    O_FRAC_MODE == $past(wr_data[scrb_pkg::BIT_FRAC_MODE]))
    else $error("Synthesizer mode not loaded from its register.");

  a_lock_type_load: assert property (wr_hit[scrb_pkg::ADDR_LOCK_OUT] |=>
    lock_cmos == $past(wr_data[scrb_pkg::BIT_LOCK_CMOS]))
    else $error("Lock output type not loaded.");

  a_ref_div_load: assert property (wr_hit[scrb_pkg::ADDR_REF_LOCK] |=>
    O_REF_DIV2 == $past(wr_data[scrb_pkg::BIT_REF_DIV2]) &&
    lock_en == $past(wr_data[scrb_pkg::BIT_LOCK_EN]))
    else $error("Reference divider or lock enable not loaded.");

  a_int_div_load: assert property (wr_hit[scrb_pkg::ADDR_DIV_INT] |=>
    O_INT_DIV == $past(wr_data[scrb_pkg::INT_MSB:0]) &&
    O_FRAC_DIV[scrb_pkg::FRAC_LO_MSB-scrb_pkg::FRAC_LO_LSB:0] ==
    $past(wr_data[scrb_pkg::FRAC_LO_MSB:scrb_pkg::FRAC_LO_LSB]))
    else $error("Integer divider or low fraction not loaded.");

  a_frac_high_load: assert property (wr_hit[scrb_pkg::ADDR_DIV_FRAC_H] |=>
    O_FRAC_DIV == {$past(wr_data),
    $past(O_FRAC_DIV[scrb_pkg::FRAC_LO_MSB-scrb_pkg::FRAC_LO_LSB:0])})
    else $error("High fraction not loaded.");

  a_refclk_load: assert property (wr_hit[scrb_pkg::ADDR_REFCLK] |=>
    O_REFCLK_DIV2 == $past(wr_data[scrb_pkg::BIT_REFCLK_DIV2]) &&
    O_REFCLK_EN == $past(wr_data[scrb_pkg::BIT_REFCLK_EN]))
    else $error("Reference clock output fields not loaded.");

  a_det_gain_load: assert property (wr_hit[scrb_pkg::ADDR_CAL_DET] |=>
    O_DET_GAIN == $past(wr_data[scrb_pkg::DET_GAIN_MSB:scrb_pkg::DET_GAIN_LSB]))
    else $error("Detector gain not loaded.");

  a_hp_corner_load: assert property (wr_hit[scrb_pkg::ADDR_FILT_FINE] |=>
    O_RX_HP_CORNER == $past(wr_data[scrb_pkg::HP_MSB:scrb_pkg::HP_LSB]))
    else $error("Highpass corner not loaded.");

  a_lpf_fine_load: assert property (wr_hit[scrb_pkg::ADDR_FILT_FINE] |=>
    O_TX_LPF_FINE == $past(wr_data[scrb_pkg::TX_FINE_MSB:scrb_pkg::TX_FINE_LSB]) &&
    O_RX_LPF_FINE == $past(wr_data[scrb_pkg::RX_FINE_MSB:0]))
    else $error("Lowpass fine trims not loaded.");

  a_lpf_coarse_load: assert property (wr_hit[scrb_pkg::ADDR_GAIN_IND] |=>
    O_LPF_COARSE == $past(wr_data[scrb_pkg::COARSE_MSB:0]))
    else $error("Lowpass coarse corner not loaded.");

  a_ind_sel_load: assert property (wr_hit[scrb_pkg::ADDR_GAIN_IND] |=>
    O_IND_SEL == $past(wr_data[scrb_pkg::IND_SEL_MSB:scrb_pkg::IND_SEL_LSB]))
    else $error("Indicator routing not loaded.");

  a_rx_gain_serial: assert property (r_gind[scrb_pkg::BIT_RX_SERIAL] |->
    O_RX_GAIN == r_rxg[scrb_pkg::RX_GAIN_MSB:0])
    else $error("Receive gain not taken from the register.");

  a_ind_forced_on: assert property (r_gind[scrb_pkg::BIT_IND_ALWAYS] || hp_pin_s |->
    O_IND_EN)
    else $error("Indicator not enabled when asked.");

  a_rx_cal_receive: assert property (O_RX_CAL |->
    !rx_tx_s && r_cal[scrb_pkg::BIT_RX_CAL])
    else $error("Receive calibration outside receive.");

  a_latch_single: assert property (latch_en |=> !latch_en)
    else $error("Load strobe lasted more than one cycle.");

  a_bank_hold_idle: assert property (!latch_en |=> $stable(r_lock) && $stable(r_int) &&
    $stable(r_frac) && $stable(r_ref) && $stable(r_rclk))
    else $error("Register changed without a load strobe.");

endmodule // scrb_top

// [test/scrb_ctrl_model.sv]
// Behavioural baseband controller that writes the bank over the 3-wire link.
`timescale 1ns/1ps
// ====================
// Controller model
// ====================
module scrb_ctrl_model (
  input  wire logic i_mclk,
  output logic      o_cs_b,
  output logic      o_sclk,
  output logic      o_sdata
);
  initial
  begin
    o_cs_b  = 1'b1;
    o_sclk  = 1'b0;
    o_sdata = 1'b0;
  end

  // Sends the low n bits of w, most significant first; n need not be 18.
  task automatic send(input logic [31:0] w, input int n);
    @(posedge i_mclk);
    o_cs_b <= 1'b0;
    for (int k = n - 1; k >= 0; k--)
    begin
      o_sdata <= w[k];
      repeat (3) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_mclk);
      o_sclk <= 1'b0;
      @(posedge i_mclk);
    end
    repeat (3) @(posedge i_mclk);
    o_cs_b <= 1'b1;
    // The released data line flips, so no stale bit can pass for a good one.
    o_sdata <= ~o_sdata;
  endtask

  // Clock pulses with select high; the bank must ignore every one of them.
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_mclk);
      o_sclk <= 1'b0;
      repeat (2) @(posedge i_mclk);
    end
  endtask
endmodule // scrb_ctrl_model

// [test/test_scrb_top.sv]
// Self-checking bench for the serial configuration register bank.
`timescale 1ns/1ps
// ====================
// Bench top
// ====================
module test_scrb_top;
  typedef struct { logic [17:0] w; int sel; logic [19:0] exp; } scrb_row_t;
  logic        clk, rst_b, cs_b, sclk, sdata, locked, rx_tx, hp, reg_write;
  logic        frac_mode, ref_div2, refclk_div2, refclk_en, tx_cal, rx_cal, ind_en;
  logic        lock_out, lock_oe, lock_pu;
  logic [6:0]  prx, rx_gain;
  logic [5:0]  ptx, tx_gain;
  logic [7:0]  int_div;
  logic [19:0] frac_div;
  logic [1:0]  det_gain, hp_corner, lpf_coarse, ind_sel;
  logic [2:0]  tx_fine, rx_fine;
  int          miscompares = 0;
  int          num_checks  = 0;
  logic [19:0] rv [8] = '{20'h1, 20'h79, 20'hD9980, 20'h1, 20'h1, 20'h0, 20'h62, 20'h1};
  scrb_row_t   rows [16] = '{
    '{18'h13400, 0, 20'h0}, '{18'h17400, 0, 20'h1}, '{18'h2A403, 1, 20'h40},
    '{18'h3FFF4, 2, 20'hFFFEA}, '{18'h00A05, 3, 20'h0}, '{18'h053BE, 4, 20'h2},
    '{18'h033BE, 4, 20'h1}, '{18'h00606, 5, 20'h0}, '{18'h08606, 5, 20'h1},
    '{18'h10606, 5, 20'h2}, '{18'h18606, 5, 20'h3}, '{18'h201D7, 6, 20'h9D},
    '{18'h22038, 7, 20'hB}, '{18'h21008, 7, 20'h4}, '{18'h00A45, 3, 20'h1},
    '{18'h13FF3, 1, 20'hFF}};

  scrb_top scrb_top_i (
    .I_MCLK(clk), .I_RST_B(rst_b), .I_CS_B(cs_b), .I_SCLK(sclk), .I_SDATA(sdata),
    .I_PLL_LOCKED(locked), .I_RX_TX_SELECT_PIN(rx_tx), .I_HIGHPASS_SELECT_PIN(hp),
    .I_PARALLEL_RX_GAIN_PINS(prx), .I_PARALLEL_TX_GAIN_PINS(ptx), .O_REG_WRITE(reg_write),
    .O_FRAC_MODE(frac_mode), .O_REF_DIV2(ref_div2), .O_INT_DIV(int_div),
    .O_FRAC_DIV(frac_div), .O_REFCLK_DIV2(refclk_div2), .O_REFCLK_EN(refclk_en),
    .O_DET_GAIN(det_gain), .O_TX_CAL(tx_cal), .O_RX_CAL(rx_cal), .O_RX_HP_CORNER(hp_corner),
    .O_TX_LPF_FINE(tx_fine), .O_RX_LPF_FINE(rx_fine), .O_LPF_COARSE(lpf_coarse),
    .O_RX_GAIN(rx_gain), .O_TX_GAIN(tx_gain), .O_IND_EN(ind_en), .O_IND_SEL(ind_sel),
    .O_LOCK_DET_OUT(lock_out), .O_LOCK_DET_OE(lock_oe), .O_LOCK_PULLUP_EN(lock_pu));

  scrb_ctrl_model ctrl_i (.i_mclk(clk), .o_cs_b(cs_b), .o_sclk(sclk), .o_sdata(sdata));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [19:0] pick(input int s);
    case (s)
      0: pick = {19'h0, frac_mode};
      1: pick = {12'h0, int_div};
      2: pick = frac_div;
      3: pick = {19'h0, ref_div2};
      4: pick = {18'h0, refclk_div2, refclk_en};
      5: pick = {18'h0, det_gain};
      6: pick = {12'h0, hp_corner, tx_fine, rx_fine};
      default: pick = {16'h0, ind_sel, lpf_coarse};
    endcase
  endfunction

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A frame, then the load strobe is looked for on each of six edges.
  task automatic wr(input logic [31:0] w, input int n);
    int hit;
    hit = 0;
    ctrl_i.send(w, n);
    for (int k = 1; k <= 6; k++)
    begin
      @(posedge clk);
      #1;
      if (reg_write === 1'b1) hit = hit + k;
    end
    check(20'(hit), 20'd3);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    rst_b = 1'b0;
    locked = 1'b0;
    rx_tx = 1'b0;
    hp = 1'b0;
    prx = 7'h2B;
    ptx = 6'h15;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    for (int i = 0; i < 8; i++) check(pick(i), rv[i]);
    for (int i = 0; i < 16; i++)
      wr({scrb_pkg::RESET_VAL[i], 4'(i)}, 18);
    for (int i = 0; i < 8; i++) check(pick(i), rv[i]);
    for (int i = 0; i < 16; i++)
    begin
      wr(rows[i].w, 18);
      check(pick(rows[i].sel), rows[i].exp);
    end
    // Lock pin over every mix of type, enable, pullup and lock state.
    for (int c = 0; c < 16; c++)
    begin
      logic [3:0] v;
      v = 4'(c);
      wr({14'h019A | {1'b0, v[0], 12'h0}, 4'h1}, 18);
      wr({14'h0084 | {4'h0, v[2], 3'h0, v[1], 5'h0}, 4'h5}, 18);
      locked <= v[3];
      settle();
      check({17'h0, lock_oe, lock_pu, lock_out & lock_oe}, {17'h0, v[1] & (v[0] | ~v[3]), v[1] & ~v[0] & v[2], v[1] & v[0] & v[3]});
    end
    wr(18'h00636, 18);
    for (int t = 0; t < 2; t++)
    begin
      rx_tx <= t[0];
      settle();
      check({18'h0, tx_cal, rx_cal}, {18'h0, t[0], ~t[0]});
    end
    wr(18'h005AB, 18);
    wr(18'h20018, 18);
    check({12'h0, rx_gain, ind_en}, {12'h0, 7'h2B, 1'b0});
    hp <= 1'b1;
    settle();
    check({19'h0, ind_en}, 20'h1);
    hp <= 1'b0;
    wr(18'h34018, 18);
    check({12'h0, rx_gain, ind_en}, {12'h0, 7'h5A, 1'b1});
    check({14'h0, tx_gain}, 20'h15);
    wr(18'h002DC, 18);
    wr(18'h07B59, 18);
    check({14'h0, tx_gain}, 20'h2D);
    // Over-long frame, ignored clocks, then a short frame reusing old bits.
    wr({4'hF, 14'h0011, 4'hB}, 22);
    check({13'h0, rx_gain}, 20'h11);
    ctrl_i.idle_clocks(3);
    wr({5'h0A, 4'hB}, 9);
    check({13'h0, rx_gain}, 20'h6A);
    finish_test();
  end
endmodule // test_scrb_top
